/* File: wdt_block.sv */
// Added by the designer: the register offsets and register access over APB.
module wdt_block (
	input  wire logic                         ref_clk,
	input  wire logic                         rst_b,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [wdt_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [wdt_pkg::DATA_W-1:0]   pwdata,
	output logic      [wdt_pkg::DATA_W-1:0]   prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         slow_internal_osc,
	input  wire logic                         config_watchdog_enable,
	input  wire logic                         watchdog_kick_instruction,
	input  wire logic                         sleep_instruction,
	input  wire logic                         sleep_mode,
	input  wire logic                         wake_event,
	input  wire logic                         osc_fail,
	input  wire logic                         osc_startup_timer,
	input  wire logic                         crystal_clock_sel,
	output logic                              slow_osc_request,
	output logic                              watchdog_reset,
	output logic                              watchdog_wake,
	output logic                              watchdog_expiry_flag_b,
	output logic                              sleep_entered_flag_b,
	output logic                              irq
);
	import wdt_pkg::*;

	// Whole block state in one record
	typedef struct packed {
		logic [RATE_W-1:0] rate;      // Watchdog rate select
		logic              sw_en;     // Software enable
		logic              prescaler_owner_select;       // Shared divider owner
		logic [PS_W-1:0]   ps;        // Shared divider rate
		logic [PRE_W-1:0]  pre;       // Dedicated prescaler
		logic [POST_W-1:0] post;      // Shared postscaler
		logic [IRQ_W-1:0]  irq_st;    // Sticky events
		logic [IRQ_W-1:0]  irq_en;    // Event enables
		logic              exp_b;     // Expiry flag, low after expiry
		logic              slp_b;     // Sleep flag, low after sleep
		logic              wake_hold; // Crystal wake hold
		logic              ost_q;     // Start-up timer, last cycle
		logic              osc_m;     // Sync stage one
		logic              osc_s;     // Sync stage two
		logic              osc_q;     // Edge detect delay
		wdt_mode_t         mode;      // Visible mode
		logic              rst_p;     // Core reset pulse
		logic              wake_p;    // Wake pulse
		logic [DATA_W-1:0] rdata;     // Read data latch
	} wdt_state_t;

	// Power-on contents
	localparam wdt_state_t ST_RST = '{
		rate:    RATE_RST,
		sw_en:   CTRL_EN_RST,
		prescaler_owner_select:     OPT_RST[OPT_PSA_BIT],
		ps:      OPT_RST[PS_W-1:0],
		exp_b:   1'b1,
		slp_b:   1'b1,
		mode:    WDT_OFF,
		default: '0
	};

	wdt_state_t        st_r;      // Registered state
	wdt_state_t        st_nxt;    // Next state
	logic              tick;      // One slow oscillator edge
	logic              enabled;   // Watchdog switched on
	logic              sleep_go;  // Sleep taken while enabled
	logic              ost_done;  // Start-up timer just ended
	logic              clr;       // Counter clear request
	logic [RATE_W-1:0] rate_c;    // Rate with reserved codes capped
	logic [PRE_W-1:0]  pre_mask;  // Prescaler bits in use
	logic [POST_W-1:0] post_mask; // Postscaler bits in use
	logic              pre_tc;    // Prescaler at terminal count
	logic              post_tc;   // Postscaler at terminal count
	logic              timeout;   // Watchdog expires now
	logic              apb_wr;    // Write access phase
	logic              apb_setup; // Read setup phase
	logic              addr_ok;   // Address is mapped
	logic [DATA_W-1:0] rd_val;    // Read value for paddr

	// Only edges of the second sync stage count
	assign tick = st_r.osc_s & ~st_r.osc_q;

	// Config bit overrides the software bit
	assign enabled = config_watchdog_enable | st_r.sw_en;

	assign sleep_go = sleep_instruction & enabled;
	assign ost_done = st_r.ost_q & ~osc_startup_timer;

	// Any of these holds both counters at zero
	assign clr = ~enabled
		| watchdog_kick_instruction
		| osc_fail
		| osc_startup_timer
		| wake_event
		| st_r.wake_hold
		| sleep_go;

	// Reserved codes behave as the longest ratio
	assign rate_c = (st_r.rate > RATE_MAX) ? RATE_MAX : st_r.rate;

	// Code 0 keeps five bits (1:32), each step adds one
	assign pre_mask = 16'hFFFF >> (RATE_MAX - rate_c);
	assign pre_tc   = &(st_r.pre | ~pre_mask);

	// Shared divider counts prescaler wraps when owned
	assign post_mask = ~(8'hFF << st_r.ps);
	assign post_tc   = ~st_r.prescaler_owner_select | (&(st_r.post | ~post_mask));

	// A clear in the same cycle suppresses the expiry
	assign timeout = ~clr & tick & pre_tc & post_tc;

	// APB decode; no wait states
	assign apb_wr    = psel & penable & pwrite;
	assign apb_setup = psel & ~penable & ~pwrite;
	assign pready    = psel & penable;
	assign addr_ok   = (paddr == OFF_CTRL) | (paddr == OFF_OPT)
		| (paddr == OFF_IRQ_ST) | (paddr == OFF_IRQ_CLR)
		| (paddr == OFF_IRQ_EN) | (paddr == OFF_STATE);
	assign pslverr   = psel & penable & ~addr_ok;

	// Read mux; unused upper bits read zero
	always_comb begin
		case (paddr)
			OFF_CTRL: begin
				rd_val = DATA_W'({st_r.rate, st_r.sw_en});
			end
			OFF_OPT: begin
				rd_val = DATA_W'({st_r.prescaler_owner_select, st_r.ps});
			end
			OFF_IRQ_ST: begin
				rd_val = DATA_W'(st_r.irq_st);
			end
			OFF_IRQ_EN: begin
				rd_val = DATA_W'(st_r.irq_en);
			end
			OFF_STATE: begin
				rd_val = DATA_W'({st_r.slp_b, st_r.exp_b, st_r.mode});
			end
			default: begin
				// Clear register is write-only
				rd_val = '0;
			end
		endcase
	end

	// Next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;

		// Two-stage sync of the slow oscillator pin
		st_nxt.osc_m = slow_internal_osc;
		st_nxt.osc_s = st_r.osc_m;
		st_nxt.osc_q = st_r.osc_s;
		st_nxt.ost_q = osc_startup_timer;

		// Register writes; control bits 31-5 and option bits 31-4 are dropped
		if (apb_wr) begin
			case (paddr)
				OFF_CTRL: begin
					st_nxt.rate  = pwdata[CTRL_RATE_LSB +: RATE_W];
					st_nxt.sw_en = pwdata[CTRL_EN_BIT];
				end
				OFF_OPT: begin
					st_nxt.prescaler_owner_select = pwdata[OPT_PSA_BIT];
					st_nxt.ps  = pwdata[PS_W-1:0];
				end
				OFF_IRQ_EN: begin
					st_nxt.irq_en = pwdata[IRQ_W-1:0];
				end
				default: begin
					// Status and state are read-only
				end
			endcase
		end

		// Latch read data during setup so it comes from a flop
		if (apb_setup) begin
			st_nxt.rdata = rd_val;
		end

		// Counter chain: clear, else step on each slow edge
		if (clr) begin
			st_nxt.pre  = '0;
			st_nxt.post = '0;
		end else if (tick) begin
			st_nxt.pre = st_r.pre + 16'h0001;
			if (pre_tc && st_r.prescaler_owner_select) begin
				st_nxt.post = st_r.post + 8'h01;
			end
		end

		// Crystal wake waits for the start-up count
		if (wake_event && crystal_clock_sel) begin
			st_nxt.wake_hold = 1'b1;
		end else if (ost_done) begin
			st_nxt.wake_hold = 1'b0;
		end

		// Sleep entry flags
		if (sleep_go) begin
			st_nxt.exp_b = 1'b1;
			st_nxt.slp_b = 1'b0;
		end

		// Expiry: wake when asleep, core reset otherwise
		st_nxt.rst_p  = timeout & ~sleep_mode;
		st_nxt.wake_p = timeout & sleep_mode;
		if (timeout) begin
			st_nxt.exp_b = 1'b0;
		end
		if (timeout && !sleep_mode) begin
			// The core reset reloads control and option
			st_nxt.rate  = RATE_RST;
			st_nxt.sw_en = CTRL_EN_RST;
			st_nxt.prescaler_owner_select   = OPT_RST[OPT_PSA_BIT];
			st_nxt.ps    = OPT_RST[PS_W-1:0];
		end

		// Sticky events; a new event beats a clear
		if (apb_wr && (paddr == OFF_IRQ_CLR)) begin
			st_nxt.irq_st = st_r.irq_st & ~pwdata[IRQ_W-1:0];
		end
		if (timeout && !sleep_mode) begin
			st_nxt.irq_st[IRQ_RST_BIT] = 1'b1;
		end
		if (timeout && sleep_mode) begin
			st_nxt.irq_st[IRQ_WAKE_BIT] = 1'b1;
		end

		// Visible mode follows enable and holds
		if (!enabled) begin
			st_nxt.mode = WDT_OFF;
		end else if (osc_startup_timer || st_r.wake_hold) begin
			st_nxt.mode = WDT_HOLD;
		end else begin
			st_nxt.mode = WDT_RUN;
		end
	end

	// Single state register, synchronous reset
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign prdata                 = st_r.rdata;
	assign watchdog_reset         = st_r.rst_p;
	assign watchdog_wake          = st_r.wake_p;
	assign watchdog_expiry_flag_b = st_r.exp_b;
	assign sleep_entered_flag_b   = st_r.slp_b;
	// Asks for the oscillator only; ready stays with its owner
	assign slow_osc_request       = (st_r.mode != WDT_OFF);
	// Level interrupt while an enabled event is pending
	assign irq                    = |(st_r.irq_st & st_r.irq_en);

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_off_clears: assert property (
		!enabled |=> (st_r.pre == '0) && (st_r.post == '0))
		else $error("disabled watchdog did not clear");

	a_kick_clears: assert property (
		watchdog_kick_instruction |=> (st_r.pre == '0) && (st_r.post == '0))
		else $error("kick did not clear both dividers");

	a_ost_holds: assert property (
		(osc_startup_timer && enabled) |=> (st_r.pre == '0) && (st_r.mode == WDT_HOLD))
		else $error("start-up timer did not hold watchdog");

	a_cfg_forces_on: assert property (
		config_watchdog_enable |=> (st_r.mode != WDT_OFF) && slow_osc_request)
		else $error("config enable did not force watchdog on");

	a_sw_enable: assert property (
		(apb_wr && (paddr == OFF_CTRL) && !timeout)
		|=> st_r.sw_en == $past(pwdata[CTRL_EN_BIT]))
		else $error("software enable not stored");

	a_unimpl_zero: assert property (
		(apb_setup && (paddr == OFF_CTRL)) |=> (prdata[DATA_W-1:5] == '0))
		else $error("unimplemented control bits read nonzero");

	a_wake_expiry: assert property (
		(timeout && sleep_mode)
		|=> watchdog_wake && !watchdog_reset && !watchdog_expiry_flag_b)
		else $error("expiry in sleep did not wake");

	a_reset_pulse: assert property (
		(timeout && !sleep_mode) |=> watchdog_reset ##1 !watchdog_reset)
		else $error("expiry reset not a single pulse");

	a_sleep_flags: assert property (
		sleep_go |=> watchdog_expiry_flag_b && !sleep_entered_flag_b && (st_r.pre == '0))
		else $error("sleep entry flags or clear wrong");

	a_wake_clears: assert property (
		wake_event |=> (st_r.pre == '0) && (st_r.post == '0))
		else $error("wake did not clear watchdog");

	a_xtal_hold: assert property (
		(wake_event && crystal_clock_sel) |=> st_r.wake_hold ##1 (st_r.pre == '0))
		else $error("crystal wake hold missing");

	a_ctrl_reset: assert property (
		$rose(rst_b) |-> (st_r.rate == RATE_RST) && !st_r.sw_en)
		else $error("control not at reset value");

	a_rate_ratio: assert property (
		(st_r.rate <= RATE_MAX)
		|-> pre_mask == PRE_W'((17'h0_0020 << st_r.rate) - 17'h0_0001))
		else $error("prescaler ratio wrong for rate code");
endmodule

/* File: wdt_pkg.sv */
package wdt_pkg;
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_OPT     = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_EN  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_STATE   = 8'h14;

	// Control register fields and reset values
	localparam int         CTRL_EN_BIT   = 0;
	localparam int         CTRL_RATE_LSB = 1;
	localparam int         RATE_W        = 4;
	localparam logic [3:0] RATE_RST      = 4'h4;
	localparam logic [3:0] RATE_MAX      = 4'hB;
	localparam logic       CTRL_EN_RST   = 1'b0;

	// Option copy: owner bit and shared rate
	localparam int         OPT_PSA_BIT = 3;
	localparam int         PS_W        = 3;
	localparam logic [3:0] OPT_RST     = 4'hF;

	// Counter widths
	localparam int PRE_W  = 16;
	localparam int POST_W = 8;

	// Interrupt events
	localparam int IRQ_W        = 2;
	localparam int IRQ_RST_BIT  = 0;
	localparam int IRQ_WAKE_BIT = 1;

	// Nominal source rate, for reference only
	localparam int SLOW_OSC_HZ = 31000;

	// Watchdog operating mode
	typedef enum logic [2:0] {
		WDT_OFF  = 3'b001,
		WDT_HOLD = 3'b010,
		WDT_RUN  = 3'b100
	} wdt_mode_t;
endpackage

/* File: wdt_block_test.sv */
module wdt_block_test;
	timeunit 1ns;
	timeprecision 1ps;
	import wdt_pkg::*;

	// Stimulus and observation nets
	logic              ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd_d;
	logic              slow_internal_osc, config_watchdog_enable, watchdog_kick_instruction;
	logic              sleep_instruction, sleep_mode, wake_event, osc_fail, osc_startup_timer;
	logic              crystal_clock_sel, slow_osc_request, watchdog_reset, watchdog_wake;
	logic              watchdog_expiry_flag_b, sleep_entered_flag_b, rd_e;
	int                fails, cmp_count, n_rst, n_wake, cyc;
	logic [31:0]       rnd_s = 32'h0000_0031;
	int                rr, ps, own;
	logic [31:0]       wv;

	wdt_block dut_u (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .slow_internal_osc, .config_watchdog_enable,
		.watchdog_kick_instruction, .sleep_instruction, .sleep_mode, .wake_event, .osc_fail,
		.osc_startup_timer, .crystal_clock_sel, .slow_osc_request, .watchdog_reset,
		.watchdog_wake, .watchdog_expiry_flag_b, .sleep_entered_flag_b, .irq);

	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Pulse counters, plus a hang guard well above the longest expected run
	always @(posedge ref_clk) begin
		if (watchdog_reset === 1'b1) n_rst++;
		if (watchdog_wake === 1'b1) n_wake++;
		cyc++;
		if (cyc == 60000) begin
			fails++;
			final_report();
		end
	end

	// Repeatable xorshift source
	function automatic logic [31:0] xs();
		rnd_s = rnd_s ^ (rnd_s << 13);
		rnd_s = rnd_s ^ (rnd_s >> 17);
		rnd_s = rnd_s ^ (rnd_s << 5);
		return rnd_s;
	endfunction

	// Ticks to expiry; reserved rate codes saturate at the longest ratio
	function automatic int exp_ticks(input int r, input int o, input int p);
		if (r > 11) r = 11;
		return (1 << (r + 5)) * (o ? (1 << p) : 1);
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; waits on pready rather than assuming zero wait states
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the global hang guard ends this wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd_d = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// A write lands at the edge above; let it reach the registers first
		@(posedge ref_clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("rd %h", a), rd_d, e);
	endtask

	// Each tick is one slow-oscillator period of eight reference cycles
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge ref_clk) slow_internal_osc <= 1'b1;
			repeat (4) @(posedge ref_clk);
			slow_internal_osc <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask

	// One-cycle event: 0 kick, 1 oscillator failure, 2 wake, 3 sleep
	task automatic pulse(input int k);
		@(posedge ref_clk);
		case (k)
			0: watchdog_kick_instruction <= 1'b1;
			1: osc_fail <= 1'b1;
			2: wake_event <= 1'b1;
			default: sleep_instruction <= 1'b1;
		endcase
		@(posedge ref_clk);
		watchdog_kick_instruction <= 1'b0;
		osc_fail          <= 1'b0;
		wake_event        <= 1'b0;
		sleep_instruction <= 1'b0;
	endtask

	// Silent for tot-1 ticks, then exactly one reset or wake pulse
	task automatic expire(input int tot, input logic asleep);
		int r0;
		int w0;
		r0 = n_rst;
		w0 = n_wake;
		ticks(tot - 1);
		chk("early", n_rst + n_wake - r0 - w0, 0);
		ticks(1);
		repeat (4) @(posedge ref_clk);
		chk("reset", n_rst - r0, asleep ? 0 : 1);
		chk("wake", n_wake - w0, asleep ? 1 : 0);
	endtask

	task automatic final_report();
		if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		{rst_b, psel, penable, pwrite, paddr, pwdata, slow_internal_osc} = '0;
		{config_watchdog_enable, watchdog_kick_instruction, sleep_instruction} = '0;
		{sleep_mode, wake_event, osc_fail, osc_startup_timer, crystal_clock_sel} = '0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		rchk(OFF_CTRL, 32'h0000_0008);
		rchk(OFF_OPT, 32'h0000_000F);
		rchk(OFF_STATE, 32'h0000_0019);
		// Random control writes: upper bits must drop out
		repeat (6) begin
			wv = xs();
			apb(1'b1, OFF_CTRL, wv);
			rchk(OFF_CTRL, wv & 32'h0000_001F);
		end
		// Unmapped place errors and reads zero; read-only status ignores writes
		apb(1'b0, 8'h40, 32'h0);
		chk("err", rd_e, 1'b1);
		chk("unmapped", rd_d, 32'h0);
		apb(1'b1, OFF_IRQ_ST, 32'hFFFF_FFFF);
		rchk(OFF_IRQ_ST, 32'h0);
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0003);
		// Restart paths: kick, disable, oscillator failure, each mid-count
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, OFF_OPT, 32'h0);
			apb(1'b1, OFF_CTRL, 32'h0000_0001);
			// Mode follows the enable one edge after the write
			@(posedge ref_clk) chk("osc_req", slow_osc_request, 1'b1);
			ticks(20);
			if (k == 1) begin
				apb(1'b1, OFF_CTRL, 32'h0);
				apb(1'b1, OFF_CTRL, 32'h0000_0001);
			end
			else pulse(k == 2 ? 1 : 0);
			expire(32, 1'b0);
			rchk(OFF_CTRL, 32'h0000_0008);
			rchk(OFF_STATE, 32'h0000_0011);
			chk("irq", irq, 1'b1);
			apb(1'b1, OFF_IRQ_CLR, 32'h0000_0001);
			chk("irq", irq, 1'b0);
		end
		// Sleep entry, wake restart, then expiry while asleep
		apb(1'b1, OFF_OPT, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		ticks(20);
		pulse(3);
		sleep_mode <= 1'b1;
		rchk(OFF_STATE, 32'h0000_000C);
		chk("slp_b", sleep_entered_flag_b, 1'b0);
		chk("exp_b", watchdog_expiry_flag_b, 1'b1);
		ticks(20);
		pulse(2);
		sleep_mode <= 1'b0;
		expire(32, 1'b0);
		apb(1'b1, OFF_IRQ_CLR, 32'h0000_0001);
		apb(1'b1, OFF_OPT, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		ticks(20);
		pulse(3);
		sleep_mode <= 1'b1;
		expire(32, 1'b1);
		rchk(OFF_STATE, 32'h0000_0004);
		chk("exp_b", watchdog_expiry_flag_b, 1'b0);
		sleep_mode <= 1'b0;
		rchk(OFF_IRQ_ST, 32'h0000_0002);
		// Masking and clearing of the wake event
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0001);
		chk("irq", irq, 1'b0);
		apb(1'b1, OFF_IRQ_EN, 32'h0000_0002);
		chk("irq", irq, 1'b1);
		apb(1'b1, OFF_IRQ_CLR, 32'h0000_0002);
		chk("irq", irq, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h0);
		// Configuration enable overrides a cleared software bit
		@(posedge ref_clk) config_watchdog_enable <= 1'b1;
		expire(32, 1'b0);
		@(posedge ref_clk) config_watchdog_enable <= 1'b0;
		// Start-up timer holds the count cleared while active
		@(posedge ref_clk) osc_startup_timer <= 1'b1;
		apb(1'b1, OFF_OPT, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		rr = n_rst;
		ticks(40);
		chk("held", n_rst - rr, 0);
		@(posedge ref_clk) osc_startup_timer <= 1'b0;
		expire(32, 1'b0);
		// Crystal wake: count stays cleared until the start-up timer ends
		apb(1'b1, OFF_OPT, 32'h0);
		apb(1'b1, OFF_CTRL, 32'h0000_0001);
		crystal_clock_sel <= 1'b1;
		rr = n_rst;
		pulse(2);
		ticks(40);
		chk("xtal_held", n_rst - rr, 0);
		@(posedge ref_clk) osc_startup_timer <= 1'b1;
		@(posedge ref_clk) osc_startup_timer <= 1'b0;
		crystal_clock_sel <= 1'b0;
		expire(32, 1'b0);
		// Random rate and owner choices, shared postscaler in the chain
		repeat (3) begin
			rr  = xs() % 3;
			ps  = xs() % 3;
			own = xs() % 2;
			apb(1'b1, OFF_OPT, 32'(own * 8 + ps));
			apb(1'b1, OFF_CTRL, 32'(rr * 2 + 1));
			expire(exp_ticks(rr, own, ps), 1'b0);
		end
		final_report();
	end
endmodule
